/* File: design/usd_shadow_port.sv */
`timescale 1ns/1ns
module usd_shadow_port #(
    parameter int TX_DEPTH = usd_pkg::TX_DEPTH_DEF,
    parameter int RX_DEPTH = usd_pkg::RX_DEPTH_DEF
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [31:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    input wire logic sin,
    input wire logic sir_in,
    output logic sout,
    output logic sir_out_n,
    output logic irq
);
    localparam int TPW = $clog2(TX_DEPTH);
    localparam int RPW = $clog2(RX_DEPTH);
    localparam int TCW = $clog2(TX_DEPTH + 1);
    localparam int RCW = $clog2(RX_DEPTH + 1);

    generate
        if (TX_DEPTH < 2 || RX_DEPTH < 2) begin : g_bad_depth
            $error("FIFO depths must be at least 2");
        end
    endgenerate

    logic fifo_en, ir_mode;
    logic [2:0] isr, imr;
    logic [15:0] div, div_cnt;
    logic tick;
    logic sin_s1, sin_s2, ir_s1, ir_s2;
    logic [4:0] ir_hold;
    logic rx_line, rx_valid;
    logic [7:0] rx_byte;
    logic [7:0] rxq [RX_DEPTH];
    logic [7:0] txq [TX_DEPTH];
    logic [RPW-1:0] rx_rd, rx_wr;
    logic [TPW-1:0] tx_rd, tx_wr;
    logic [RCW-1:0] rx_cnt;
    logic [TCW-1:0] tx_cnt;
    logic overrun_flag;
    logic tx_busy, tx_line;
    logic [3:0] tx_phase;

    // Address decode
    logic alias_hit, alias_rd, alias_wr, ctrl_wr, lsr_rd, isr_wr, imr_wr, div_wr;
    assign alias_hit = addr >= usd_pkg::ALIAS_BASE && addr <= usd_pkg::ALIAS_LAST
        && addr[1:0] == 2'b00;
    assign alias_rd = rd_en && alias_hit;
    assign alias_wr = wr_en && alias_hit;
    assign ctrl_wr = wr_en && addr == usd_pkg::CTRL_OFS;
    assign lsr_rd = rd_en && addr == usd_pkg::LSR_OFS;
    assign isr_wr = wr_en && addr == usd_pkg::ISR_OFS;
    assign imr_wr = wr_en && addr == usd_pkg::IMR_OFS;
    assign div_wr = wr_en && addr == usd_pkg::DIV_OFS;

    // FIFO state and status
    logic rx_full, tx_full, rx_dr, tx_tx_holding_empty_flag, rx_pop, rx_push, tx_pop, tx_push;
    logic rx_ovr_ev, fifo_flip;
    logic [7:0] rx_head, tx_head;
    // FIFO off behaves as a one-entry queue pinned at slot 0
    assign rx_full = fifo_en ? (rx_cnt == RCW'(RX_DEPTH)) : (rx_cnt != '0);
    assign tx_full = fifo_en ? (tx_cnt == TCW'(TX_DEPTH)) : (tx_cnt != '0);
    assign rx_dr = rx_cnt != '0;
    assign tx_tx_holding_empty_flag = tx_cnt == '0;
    assign rx_head = rxq[rx_rd];
    assign tx_head = txq[tx_rd];
    assign rx_pop = alias_rd && rx_dr;
    assign rx_push = rx_valid && (!rx_full || rx_pop || !fifo_en);
    assign rx_ovr_ev = rx_valid && rx_full && !rx_pop;
    assign tx_pop = !tx_busy && !tx_tx_holding_empty_flag;
    assign tx_push = alias_wr && (!tx_full || tx_pop || !fifo_en);
    assign fifo_flip = ctrl_wr && wr_data[usd_pkg::CTRL_FIFO_EN_BIT] != fifo_en;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fifo_en <= usd_pkg::CTRL_RESET[usd_pkg::CTRL_FIFO_EN_BIT];
            ir_mode <= usd_pkg::CTRL_RESET[usd_pkg::CTRL_IR_BIT];
            imr <= usd_pkg::INT_RESET;
            div <= usd_pkg::DIV_RESET;
        end else begin
            if (ctrl_wr) begin
                fifo_en <= wr_data[usd_pkg::CTRL_FIFO_EN_BIT];
                ir_mode <= wr_data[usd_pkg::CTRL_IR_BIT];
            end
            if (imr_wr) begin
                imr <= wr_data[2:0];
            end
            if (div_wr) begin
                div <= wr_data[15:0];
            end
        end
    end

    // 16x bit-rate enable; divisor 0 behaves as 1
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt <= 16'h0000;
            tick <= 1'b0;
        end else begin
            tick <= div_cnt == 16'h0000;
            div_cnt <= (div_cnt == 16'h0000) ? div - 16'h0001 : div_cnt - 16'h0001;
            if (div == 16'h0000) begin
                div_cnt <= 16'h0000;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sin_s1 <= 1'b1;
            sin_s2 <= 1'b1;
            ir_s1 <= 1'b0;
            ir_s2 <= 1'b0;
        end else begin
            sin_s1 <= sin;
            sin_s2 <= sin_s1;
            ir_s1 <= sir_in;
            ir_s2 <= ir_s1;
        end
    end

    // Short infrared pulses stretched to one bit so mid-bit sampling sees them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ir_hold <= 5'h00;
        end else if (ir_s2) begin
            ir_hold <= usd_pkg::IR_STRETCH;
        end else if (tick && ir_hold != 5'h00) begin
            ir_hold <= ir_hold - 5'h01;
        end
    end
    assign rx_line = ir_mode ? (ir_hold == 5'h00) : sin_s2;

    usd_rx u_rx (
        .clk(clk),
        .resetn(resetn),
        .tick(tick),
        .line(rx_line),
        .data(rx_byte),
        .valid(rx_valid)
    );

    // Receive queue; cleared so an alias read before any character returns zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < RX_DEPTH; i++) begin
                rxq[i] <= usd_pkg::DATA_RESET;
            end
        end else if (rx_push) begin
            rxq[fifo_en ? rx_wr : '0] <= rx_byte;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_rd <= '0;
            rx_wr <= '0;
            rx_cnt <= '0;
        end else if (fifo_flip) begin
            rx_rd <= '0;
            rx_wr <= '0;
            rx_cnt <= '0;
        end else begin
            if (fifo_en && rx_pop) begin
                rx_rd <= (rx_rd == RPW'(RX_DEPTH - 1)) ? '0 : rx_rd + 1'b1;
            end
            if (fifo_en && rx_push) begin
                rx_wr <= (rx_wr == RPW'(RX_DEPTH - 1)) ? '0 : rx_wr + 1'b1;
            end
            if (rx_push && !rx_pop && !rx_full) begin
                rx_cnt <= rx_cnt + 1'b1;
            end else if (rx_pop && !rx_push) begin
                rx_cnt <= rx_cnt - 1'b1;
            end
        end
    end

    // Transmit queue
    always_ff @(posedge clk) begin
        if (tx_push) begin
            txq[fifo_en ? tx_wr : '0] <= wr_data[7:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_rd <= '0;
            tx_wr <= '0;
            tx_cnt <= '0;
        end else if (fifo_flip) begin
            tx_rd <= '0;
            tx_wr <= '0;
            tx_cnt <= '0;
        end else begin
            if (fifo_en && tx_pop) begin
                tx_rd <= (tx_rd == TPW'(TX_DEPTH - 1)) ? '0 : tx_rd + 1'b1;
            end
            if (fifo_en && tx_push) begin
                tx_wr <= (tx_wr == TPW'(TX_DEPTH - 1)) ? '0 : tx_wr + 1'b1;
            end
            // Replacing the held character leaves the count alone
            if (tx_push && !tx_pop && !tx_full) begin
                tx_cnt <= tx_cnt + 1'b1;
            end else if (tx_pop && !tx_push) begin
                tx_cnt <= tx_cnt - 1'b1;
            end
        end
    end

    usd_tx u_tx (
        .clk(clk),
        .resetn(resetn),
        .tick(tick),
        .start(tx_pop),
        .data(tx_head),
        .busy(tx_busy),
        .line(tx_line),
        .phase(tx_phase)
    );

    // Infrared zero is a low pulse of 3/16 bit; idle serial line parks high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sout <= 1'b1;
            sir_out_n <= 1'b1;
        end else begin
            sout <= ir_mode ? 1'b1 : tx_line;
            sir_out_n <= !(ir_mode && !tx_line && tx_phase < usd_pkg::IR_PULSE_TICKS);
        end
    end

    // Overrun: cleared by reading line status, a new event wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            overrun_flag <= 1'b0;
        end else if (rx_ovr_ev) begin
            overrun_flag <= 1'b1;
        end else if (lsr_rd) begin
            overrun_flag <= 1'b0;
        end
    end

    // Sticky events, write one to clear, set wins
    logic tx_holding_empty_flag_q;
    logic [2:0] int_ev;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_holding_empty_flag_q <= 1'b1;
        end else begin
            tx_holding_empty_flag_q <= tx_tx_holding_empty_flag;
        end
    end
    assign int_ev = {tx_tx_holding_empty_flag && !tx_holding_empty_flag_q, rx_ovr_ev, rx_push};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            isr <= usd_pkg::INT_RESET;
            irq <= 1'b0;
        end else begin
            isr <= (isr & ~(isr_wr ? wr_data[2:0] : 3'h0)) | int_ev;
            irq <= |(isr & imr);
        end
    end

    // Read port, data one cycle after the strobe
    logic [7:0] lsr_val;
    assign lsr_val = {1'b0, tx_tx_holding_empty_flag && !tx_busy, tx_tx_holding_empty_flag, 3'h0, overrun_flag, rx_dr};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 32'h0000_0000;
        end else if (rd_en) begin
            if (alias_hit) begin
                rd_data <= {24'h00_0000, rx_head};
            end else if (addr == usd_pkg::CTRL_OFS) begin
                rd_data <= {30'h0000_0000, ir_mode, fifo_en};
            end else if (addr == usd_pkg::LSR_OFS) begin
                rd_data <= {24'h00_0000, lsr_val};
            end else if (addr == usd_pkg::ISR_OFS) begin
                rd_data <= {29'h0000_0000, isr};
            end else if (addr == usd_pkg::IMR_OFS) begin
                rd_data <= {29'h0000_0000, imr};
            end else if (addr == usd_pkg::DIV_OFS) begin
                rd_data <= {16'h0000, div};
            end else begin
                rd_data <= 32'h0000_0000;
            end
        end else begin
            rd_data <= 32'h0000_0000;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    alias_reach_a: assert property (fifo_en && alias_wr && !tx_full && !tx_pop && !fifo_flip
        |=> tx_cnt == $past(tx_cnt) + 1'b1) else $error("alias write lost");
    upper_zero_a: assert property (alias_rd |=> rd_data[31:8] == 24'h00_0000)
        else $error("alias upper bits not zero");
    ir_input_a: assert property (ir_mode && ir_s2 |=> !rx_line)
        else $error("infrared pulse not seen");
    empty_read_a: assert property (alias_rd && !rx_dr && !rx_valid && !fifo_flip
        |=> rx_cnt == '0) else $error("empty read changed queue");
    overwrite_a: assert property (!fifo_en && rx_valid && rx_dr && !rx_pop && !fifo_flip
        |=> overrun_flag && rx_head == $past(rx_byte)) else $error("no overwrite");
    head_read_a: assert property (fifo_en && rx_pop
        |=> rd_data[7:0] == $past(rx_head)) else $error("wrong head");
    full_keep_a: assert property (fifo_en && rx_full && rx_valid && !rx_pop && !fifo_flip
        |=> rx_cnt == $past(rx_cnt) && overrun_flag) else $error("full rx altered");
    ir_out_a: assert property (ir_mode && $past(ir_mode) |-> sout)
        else $error("serial out active in infrared");
    tx_holding_empty_flag_clear_a: assert property (!fifo_en && tx_tx_holding_empty_flag && alias_wr && tx_busy && !fifo_flip
        |=> !tx_tx_holding_empty_flag) else $error("holding empty not cleared");
    replace_a: assert property (!fifo_en && !tx_tx_holding_empty_flag && alias_wr && !tx_pop && !fifo_flip
        |=> tx_cnt == TCW'(1) && tx_head == $past(wr_data[7:0]))
        else $error("pending char not replaced");
    tx_drop_a: assert property (fifo_en && alias_wr && tx_full && !tx_pop && !fifo_flip
        |=> tx_cnt == TCW'(TX_DEPTH) && tx_head == $past(tx_head))
        else $error("full tx altered");
    ovr_flag_a: assert property (rx_ovr_ev ##1 !lsr_rd [*2] |-> overrun_flag)
        else $error("overrun not held");

    rx_overrun_c: cover property (fifo_en && rx_ovr_ev);
    tx_fill_c: cover property (fifo_en && tx_full && alias_wr);
    ir_frame_c: cover property (ir_mode && !sir_out_n);
    replace_c: cover property (!fifo_en && !tx_tx_holding_empty_flag && alias_wr);
endmodule // usd_shadow_port

/* File: common/usd_pkg.sv */
package usd_pkg;
    // Sixteen word aliases of the same data path
    localparam logic [31:0] ALIAS_BASE = 32'h5000_1130;
    localparam logic [31:0] ALIAS_LAST = 32'h5000_116c;
    localparam logic [31:0] UART_SECOND_SHADOW_DATA_ALIAS_13 = 32'h5000_1164;
    localparam logic [31:0] CTRL_OFS = 32'h5000_1180;
    localparam logic [31:0] LSR_OFS = 32'h5000_1184;
    localparam logic [31:0] ISR_OFS = 32'h5000_1188;
    localparam logic [31:0] IMR_OFS = 32'h5000_118c;
    localparam logic [31:0] DIV_OFS = 32'h5000_1190;
    localparam int CTRL_FIFO_EN_BIT = 0;
    localparam int CTRL_IR_BIT = 1;
    localparam int LSR_DR_BIT = 0;
    localparam int LSR_OE_BIT = 1;
    localparam int LSR_TX_HOLDING_EMPTY_FLAG_BIT = 5;
    localparam int LSR_TEMT_BIT = 6;
    localparam int INT_RX_BIT = 0;
    localparam int INT_OE_BIT = 1;
    localparam int INT_TX_HOLDING_EMPTY_FLAG_BIT = 2;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [2:0] INT_RESET = 3'h0;
    localparam logic [15:0] DIV_RESET = 16'h000b;
    localparam int TX_DEPTH_DEF = 16;
    localparam int RX_DEPTH_DEF = 16;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [4:0] IR_STRETCH = 5'h10;
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_START = 2'b01,
        SER_DATA = 2'b10,
        SER_STOP = 2'b11
    } usd_ser_state_t;
endpackage

/* File: design/usd_rx.sv */
`timescale 1ns/1ns
module usd_rx (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic line,
    output logic [7:0] data,
    output logic valid
);
    usd_pkg::usd_ser_state_t st;
    logic [3:0] tcnt;
    logic [2:0] bcnt;
    logic [7:0] shreg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= usd_pkg::SER_IDLE;
            tcnt <= 4'h0;
            bcnt <= 3'h0;
            shreg <= usd_pkg::DATA_RESET;
            data <= usd_pkg::DATA_RESET;
            valid <= 1'b0;
        end else begin
            valid <= 1'b0;
            if (tick) begin
                tcnt <= tcnt + 4'h1;
                case (st)
                    usd_pkg::SER_IDLE: begin
                        tcnt <= 4'h0;
                        if (!line) begin
                            st <= usd_pkg::SER_START;
                        end
                    end
                    usd_pkg::SER_START: begin
                        // Recheck at mid start bit to reject glitches
                        if (tcnt == usd_pkg::TICK_MID) begin
                            tcnt <= 4'h0;
                            bcnt <= 3'h0;
                            st <= line ? usd_pkg::SER_IDLE : usd_pkg::SER_DATA;
                        end
                    end
                    usd_pkg::SER_DATA: begin
                        if (tcnt == usd_pkg::TICK_LAST) begin
                            shreg <= {line, shreg[7:1]};
                            bcnt <= bcnt + 3'h1;
                            if (bcnt == usd_pkg::BIT_LAST) begin
                                st <= usd_pkg::SER_STOP;
                            end
                        end
                    end
                    usd_pkg::SER_STOP: begin
                        if (tcnt == usd_pkg::TICK_LAST) begin
                            st <= usd_pkg::SER_IDLE;
                            // Bad stop bit drops the character
                            if (line) begin
                                data <= shreg;
                                valid <= 1'b1;
                            end
                        end
                    end
                    default: st <= usd_pkg::SER_IDLE;
                endcase
            end
        end
    end
endmodule // usd_rx

/* File: design/usd_tx.sv */
`timescale 1ns/1ns
module usd_tx (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic start,
    input wire logic [7:0] data,
    output logic busy,
    output logic line,
    output logic [3:0] phase
);
    usd_pkg::usd_ser_state_t st;
    logic [2:0] bcnt;
    logic [7:0] shreg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= usd_pkg::SER_IDLE;
            busy <= 1'b0;
            line <= 1'b1;
            phase <= 4'h0;
            bcnt <= 3'h0;
            shreg <= usd_pkg::DATA_RESET;
        end else begin
            case (st)
                usd_pkg::SER_IDLE: begin
                    if (start) begin
                        shreg <= data;
                        busy <= 1'b1;
                        line <= 1'b0;
                        phase <= 4'h0;
                        bcnt <= 3'h0;
                        st <= usd_pkg::SER_START;
                    end
                end
                usd_pkg::SER_START: begin
                    if (tick) begin
                        phase <= phase + 4'h1;
                        if (phase == usd_pkg::TICK_LAST) begin
                            line <= shreg[0];
                            st <= usd_pkg::SER_DATA;
                        end
                    end
                end
                usd_pkg::SER_DATA: begin
                    if (tick) begin
                        phase <= phase + 4'h1;
                        if (phase == usd_pkg::TICK_LAST) begin
                            bcnt <= bcnt + 3'h1;
                            shreg <= {1'b1, shreg[7:1]};
                            line <= (bcnt == usd_pkg::BIT_LAST) ? 1'b1 : shreg[1];
                            if (bcnt == usd_pkg::BIT_LAST) begin
                                st <= usd_pkg::SER_STOP;
                            end
                        end
                    end
                end
                usd_pkg::SER_STOP: begin
                    if (tick) begin
                        phase <= phase + 4'h1;
                        if (phase == usd_pkg::TICK_LAST) begin
                            busy <= 1'b0;
                            st <= usd_pkg::SER_IDLE;
                        end
                    end
                end
                default: st <= usd_pkg::SER_IDLE;
            endcase
        end
    end
endmodule // usd_tx

/* File: sim/usd_peer.sv */
`timescale 1ns/1ns
module usd_peer (
    input wire logic clk,
    input wire logic ir,
    input wire logic sout,
    input wire logic sir_out_n,
    output logic sin,
    output logic sir_in
);
    // Sixteen ticks a bit with the divider set to one
    localparam int BIT_CLKS = 16;
    logic [7:0] got[$];
    logic [7:0] b;
    wire ln = ir ? sir_out_n : sout;
    initial begin
        sin = 1'b1;
        sir_in = 1'b0;
    end
    // Serial idles high; infrared idles low, a short high pulse per zero bit
    task automatic send(input logic [7:0] ch);
        logic [9:0] fr;
        fr = {1'b1, ch, 1'b0};
        for (int i = 0; i < 10; i++) begin
            sin <= ir | fr[i];
            sir_in <= ~ir ? 1'b0 : ~fr[i];
            repeat (3) @(posedge clk);
            sir_in <= 1'b0;
            repeat (BIT_CLKS - 3) @(posedge clk);
        end
    endtask
    // Serial sampled mid-bit, infrared inside the low pulse
    initial forever begin
        @(negedge ln);
        repeat (ir ? 1 : BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            b[i] = ln;
        end
        got.push_back(b);
        repeat (BIT_CLKS) @(posedge clk);
    end
endmodule // usd_peer

/* File: sim/tb_usd_shadow_port.sv */
`timescale 1ns/1ns
module tb_usd_shadow_port;
    // Smallest depths so full queues are reached in a few frames
    localparam int DEPTH = 2;
    localparam logic [31:0] A13 = usd_pkg::UART_SECOND_SHADOW_DATA_ALIAS_13;
    localparam logic [31:0] LINE_STATUS_REGISTER = usd_pkg::LSR_OFS;
    localparam logic [31:0] CTRL = usd_pkg::CTRL_OFS;
    logic clk, resetn, wr_en, rd_en, sout, sir_out_n, irq, sin, sir_in, ir;
    logic [31:0] addr, wr_data, rd_data;
    int miscompares = 0;
    int num_checks = 0;

    usd_shadow_port #(.TX_DEPTH(DEPTH), .RX_DEPTH(DEPTH)) dut_u (
        .clk(clk), .resetn(resetn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .sin(sin), .sir_in(sir_in), .sout(sout),
        .sir_out_n(sir_out_n), .irq(irq));
    usd_peer peer_u (.clk(clk), .ir(ir), .sout(sout), .sir_out_n(sir_out_n),
        .sin(sin), .sir_in(sir_in));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One-cycle strobe; dropped at the edge that takes the write
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic idle();
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        wr_en <= 1'b0;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(rd_data, exp, what);
    endtask
    task automatic rx(input logic [7:0] ch);
        peer_u.send(ch);
        repeat (8) @(posedge clk);
    endtask
    task automatic wait_tx(input int n);
        for (int i = 0; i < 400 * n && peer_u.got.size() < n; i++) @(posedge clk);
        repeat (32) @(posedge clk);
    endtask
    task automatic txc(input logic [7:0] e);
        chk(peer_u.got.size() > 0 ? {24'h0, peer_u.got.pop_front()} : 32'hx, {24'h0, e}, "tx");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        resetn = 1'b0;
        addr = '0;
        wr_data = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        ir = 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rdc(A13, 32'h0, "alias reset");
        rdc(LINE_STATUS_REGISTER, 32'h60, "lsr reset");
        rdc(32'h5000_1194, 32'h0, "unmapped");
        wr(usd_pkg::DIV_OFS, 32'h1);
        rdc(usd_pkg::DIV_OFS, 32'h1, "div");
        $display("test reset done");
        rx(8'h5a);
        rx(8'hc3);
        rdc(LINE_STATUS_REGISTER, 32'h63, "lsr overrun");
        rdc(A13, 32'hc3, "rx overwrite");
        rdc(LINE_STATUS_REGISTER, 32'h60, "lsr read");
        rdc(usd_pkg::ISR_OFS, 32'h3, "isr");
        wr(usd_pkg::IMR_OFS, 32'h2);
        rdc(usd_pkg::IMR_OFS, 32'h2, "imr");
        chk({31'h0, irq}, 32'h1, "irq on");
        wr(usd_pkg::IMR_OFS, 32'h0);
        wr(usd_pkg::ISR_OFS, 32'h2);
        rdc(usd_pkg::ISR_OFS, 32'h1, "isr clear");
        chk({31'h0, irq}, 32'h0, "irq off");
        $display("test rx overrun done");
        wr(CTRL, 32'h1);
        rdc(CTRL, 32'h1, "ctrl");
        rx(8'h11);
        rx(8'h22);
        rx(8'h33);
        rdc(LINE_STATUS_REGISTER, 32'h63, "lsr fifo full");
        rdc(usd_pkg::ALIAS_BASE, 32'h11, "rx head");
        rdc(usd_pkg::ALIAS_LAST, 32'h22, "rx kept");
        rdc(LINE_STATUS_REGISTER, 32'h60, "lsr empty");
        $display("test rx fifo done");
        wr(CTRL, 32'h3);
        idle();
        ir = 1'b1;
        rx(8'ha5);
        rdc(A13, 32'ha5, "ir rx");
        wr(A13, 32'hffff_ff3c);
        idle();
        wait_tx(1);
        txc(8'h3c);
        chk({31'h0, sout}, 32'h1, "sout ir");
        rdc(usd_pkg::ISR_OFS, 32'h7, "isr events");
        $display("test infrared done");
        ir = 1'b0;
        wr(CTRL, 32'h0);
        wr(A13, 32'h44);
        idle();
        rdc(LINE_STATUS_REGISTER, 32'h20, "holding taken");
        wr(usd_pkg::ALIAS_BASE, 32'h55);
        wr(usd_pkg::ALIAS_LAST, 32'h66);
        rdc(LINE_STATUS_REGISTER, 32'h0, "holding full");
        wait_tx(2);
        txc(8'h44);
        txc(8'h66);
        $display("test tx single done");
        wr(CTRL, 32'h1);
        for (int i = 0; i < 4; i++)
            wr(usd_pkg::ALIAS_BASE + 32'(4 * i), 32'h71 + 32'(i));
        rdc(LINE_STATUS_REGISTER, 32'h0, "tx fifo busy");
        wait_tx(3);
        txc(8'h71);
        txc(8'h72);
        txc(8'h73);
        repeat (200) @(posedge clk);
        chk(32'(peer_u.got.size()), 32'h0, "tx dropped");
        $display("test tx fifo done");
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule // tb_usd_shadow_port
